// ==== shared/tsh_defs.vh ====
// Constants for the time switch host port: offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TSH_DEFS_VH
`define TSH_DEFS_VH

// ----------------------------------------
// Direct addressing by register select line
// ----------------------------------------
`define TSH_SEL_DIRECT 1'h0
`define TSH_SEL_PORT 1'h1

// ----------------------------------------
// Indirect addresses and byte positions
// ----------------------------------------
`define TSH_ADDR_SETUP 8'hfe
`define TSH_ADDR_FSHIFT 8'hff
`define TSH_IDX_CTL 2'h0
`define TSH_IDX_DATA 2'h1
`define TSH_IDX_ADDR 2'h2
`define TSH_CTL_TGT_HI 5
`define TSH_CTL_TGT_LO 4
`define TSH_CTL_SPARE 1
`define TSH_CTL_DIR 0

// ----------------------------------------
// Operating control and condition flags
// ----------------------------------------
`define TSH_OC_ABORT_BIT 6
`define TSH_CF_PEND_BIT 7
`define TSH_CF_MRST_BIT 6
`define TSH_CF_LOSS_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSH_OC_RST 8'h00
`define TSH_SETUP_RST 8'hff
`define TSH_FSHIFT_RST 8'h00
`define TSH_SETUP_RD_ONES 6'h3f

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSH_CLK_MHZ 10
`define TSH_ACCESS_NS 900
`define TSH_ACCESS_CYC ((`TSH_ACCESS_NS * `TSH_CLK_MHZ) / 1000)

`endif

// ==== hw/tsh_sync.v ====
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes the pins are asynchronous to clk_sys_i; only stage two is read.
module tsh_sync #(
    parameter W = 8,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clk_sys_i,           // System clock
    input wire rst_b_i,             // Async reset, active low
    input wire [W-1:0] async_i,     // Raw pin levels
    output reg [W-1:0] sync_o       // Synchronised levels
);

    reg [W-1:0] meta_q;

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// ==== hw/tsh_map_mem.v ====
// Connection map storage: flip-flop array, one write port, a combinational
// host read port and a registered read port for the output timing logic.
// Assumes one write per cycle from the host port control.
module tsh_map_mem #(
    parameter DEPTH = 256,
    parameter AW = 8,
    parameter DW = 10
) (
    input wire clk_sys_i,              // System clock
    input wire rst_b_i,                // Async reset, active low
    input wire wr_en_i,                // Write strobe, one cycle
    input wire [AW-1:0] wr_addr_i,     // Write location
    input wire [DW-1:0] wr_data_i,     // Write word
    input wire [AW-1:0] host_addr_i,   // Host read location
    output wire [DW-1:0] host_data_o,  // Host read word, combinational
    input wire [AW-1:0] scan_addr_i,   // Timing read location
    output reg [DW-1:0] scan_data_o    // Timing read word, registered
);

    reg [DW-1:0] cell_q [0:DEPTH-1];

    // ----------------------------------------
    // Storage cells
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_cell
            localparam [31:0] CELL_IDX = gi;
            always @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    cell_q[gi] <= {DW{1'b0}};
                end else if (wr_en_i && (wr_addr_i == CELL_IDX[AW-1:0])) begin
                    cell_q[gi] <= wr_data_i;
                end
            end
        end
    endgenerate

    assign host_data_o = cell_q[host_addr_i];

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scan_data_o <= {DW{1'b0}};
        end else begin
            scan_data_o <= cell_q[scan_addr_i];
        end
    end

endmodule

// ==== hw/tsh_host_port.v ====
// Eight-bit host port of a time-slot switch: direct control and flag
// registers plus the three-byte indirect port to the setup, frame shift
// and connection map storage.
// Assumes host pins are asynchronous; all are synchronised before use,
// so strobes must last several clk_sys_i periods.
`include "tsh_defs.vh"

// Notes on behaviour
// [RQ1] Accesses ignored unless chip select low
// [RQ2] Control write-only, flags read-only, others read-write
// [RQ3] Select line picks direct registers or port
// [RQ4] Indirect access is three port bytes
// [RQ5] Host checks pending and reset flags first
// [RQ6] Pending set first byte, cleared within 900ns
// [RQ7] Host idles both strobes between bytes
// [RQ8] Direct registers usable during indirect access
// [RQ9] Abort bit cancels current indirect access
// [RQ10] Target bits choose register, map read, write
// [RQ11] Direction bit chooses register read or write
// [RQ12] Address FE setup, FF frame shift
// [RQ13] Address byte is map location
// [RQ14] Map word takes control low bits high
// [RQ15] Read result overwrites data and control bits
// [RQ16] Readback sets pending, clears within 900ns
// [RQ17] Register readback shows control low bits ones
// [RQ18] Byte counter returns to control on end
module tsh_host_port #(
    parameter MAP_DEPTH = 256,
    parameter MAP_AW = 8,
    parameter MAP_DW = 10
) (
    input wire clk_sys_i,                      // System clock, 10 MHz
    input wire rst_b_i,                        // Async reset, active low
    input wire [7:0] host_bus_i,               // Host data bus in
    output reg [7:0] host_bus_o,               // Host data bus out
    output reg host_bus_oe_o,                  // Drive enable for bus
    input wire register_select_line_i,         // 0 direct, 1 port
    input wire cs_b_i,                         // Chip select, active low
    input wire wr_b_i,                         // Write strobe, active low
    input wire rd_b_i,                         // Read strobe, active low
    input wire mem_reset_busy_i,               // Map reset running
    input wire data_loss_i,                    // Data loss condition
    input wire [MAP_AW-1:0] map_scan_addr_i,   // Timing read location
    output wire [MAP_DW-1:0] map_scan_data_o,  // Timing read word
    output reg [7:0] operating_control_o,      // Control register
    output reg [7:0] setup_select_o,           // Setup register
    output reg [7:0] frame_shift_o,            // Frame shift register
    output reg pending_o                       // Indirect access busy
);

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    localparam [2:0] PH_IDLE = 3'h0;
    localparam [2:0] PH_EXEC = 3'h1;
    localparam [2:0] PH_READY = 3'h2;
    localparam [2:0] PH_RBK = 3'h3;
    localparam [2:0] PH_DONE = 3'h4;
    localparam [31:0] BUSY_FULL = `TSH_ACCESS_CYC;
    localparam [3:0] BUSY_CYC = BUSY_FULL[3:0];
    // Pin sync and commit already use three clocks of the access time
    localparam [3:0] EXEC_CYC = BUSY_CYC - 4'h3;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [11:0] pins_s;
    wire [7:0] bus_s;
    wire sel_s;
    wire cs_b_s;
    wire wr_b_s;
    wire rd_b_s;

    tsh_sync #(
        .W(12),
        .RST_VAL(12'he00)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .async_i({cs_b_i, wr_b_i, rd_b_i, register_select_line_i, host_bus_i}),
        .sync_o(pins_s)
    );

    assign bus_s = pins_s[7:0];
    assign sel_s = pins_s[8];
    assign rd_b_s = pins_s[9];
    assign wr_b_s = pins_s[10];
    assign cs_b_s = pins_s[11];

    // ----------------------------------------
    // Strobe edges
    // ----------------------------------------
    reg wr_prev_q;
    reg rd_prev_q;
    reg wr_act_q;
    reg wr_sel_q;
    reg [7:0] bus_prev_q;
    wire wr_start;
    wire wr_end;
    wire rd_start;

    // Edges only count while chip select is low, see [RQ1]
    assign wr_start = wr_prev_q & ~wr_b_s & ~cs_b_s;
    assign rd_start = rd_prev_q & ~rd_b_s & ~cs_b_s & wr_b_s;
    // Data taken one cycle before the strobe rises, to respect short hold
    assign wr_end = wr_act_q & wr_b_s;

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            wr_act_q <= 1'b0;
            wr_sel_q <= 1'b0;
            bus_prev_q <= 8'h00;
        end else begin
            wr_prev_q <= wr_b_s;
            rd_prev_q <= rd_b_s;
            bus_prev_q <= bus_s;
            if (wr_start) begin
                wr_act_q <= 1'b1;
                wr_sel_q <= sel_s;
            end else if (wr_b_s || cs_b_s) begin
                wr_act_q <= 1'b0;
            end
        end
    end

    wire oc_wr = wr_end & (wr_sel_q == `TSH_SEL_DIRECT);    // see [RQ3]
    wire port_wr = wr_end & (wr_sel_q == `TSH_SEL_PORT);    // see [RQ3]
    wire port_rd = rd_start & (sel_s == `TSH_SEL_PORT);
    wire abort = oc_wr & bus_prev_q[`TSH_OC_ABORT_BIT];     // see [RQ9]

    // ----------------------------------------
    // Indirect port state
    // ----------------------------------------
    reg [7:0] port_q [0:2];
    reg [1:0] seq_q;
    reg [2:0] phase_q;
    reg [3:0] cnt_q;
    reg op_read_q;
    reg op_reg_q;
    reg map_we_q;
    reg [MAP_AW-1:0] map_wa_q;
    reg [MAP_DW-1:0] map_wd_q;
    wire [MAP_DW-1:0] map_host_data;

    tsh_map_mem #(
        .DEPTH(MAP_DEPTH),
        .AW(MAP_AW),
        .DW(MAP_DW)
    ) u_map (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .wr_en_i(map_we_q),
        .wr_addr_i(map_wa_q),
        .wr_data_i(map_wd_q),
        .host_addr_i(port_q[`TSH_IDX_ADDR][MAP_AW-1:0]),
        .host_data_o(map_host_data),
        .scan_addr_i(map_scan_addr_i),
        .scan_data_o(map_scan_data_o)
    );

    // Decode of the assembled request, control byte already held
    wire [7:0] ctl_b = port_q[`TSH_IDX_CTL];
    wire tgt_reg = ctl_b[`TSH_CTL_TGT_HI] & ctl_b[`TSH_CTL_TGT_LO];  // see [RQ10]
    wire tgt_mrd = ~ctl_b[`TSH_CTL_TGT_HI] & ~ctl_b[`TSH_CTL_TGT_LO];  // see [RQ10]
    // Spare control bit is ignored for register accesses, see [RQ11]
    wire is_read = tgt_reg ? ctl_b[`TSH_CTL_DIR] : tgt_mrd;

    // Register read result: selected register, unmatched address gives zero
    reg [7:0] reg_rd;
    always @* begin
        case (port_q[`TSH_IDX_ADDR])
            `TSH_ADDR_SETUP: reg_rd = setup_select_o;    // see [RQ12]
            `TSH_ADDR_FSHIFT: reg_rd = frame_shift_o;    // see [RQ12]
            default: reg_rd = 8'h00;
        endcase
    end

    // Readback view of the control byte; unused bits read back as ones
    wire [7:0] ctl_rd = {2'h3, ctl_b[5:4], 2'h3, ctl_b[1:0]};
    wire [7:0] port_view = (phase_q == PH_READY || phase_q == PH_RBK) ?
        ((seq_q == `TSH_IDX_CTL) ? ctl_rd : port_q[seq_q]) : port_q[seq_q];

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port_q[0] <= 8'h00;
            port_q[1] <= 8'h00;
            port_q[2] <= 8'h00;
            seq_q <= `TSH_IDX_CTL;
            phase_q <= PH_IDLE;
            cnt_q <= 4'h0;
            op_read_q <= 1'b0;
            op_reg_q <= 1'b0;
            pending_o <= 1'b0;
            map_we_q <= 1'b0;
            map_wa_q <= {MAP_AW{1'b0}};
            map_wd_q <= {MAP_DW{1'b0}};
            setup_select_o <= `TSH_SETUP_RST;
            frame_shift_o <= `TSH_FSHIFT_RST;
        end else begin
            map_we_q <= 1'b0;
            if (abort) begin
                // Cancel wherever the sequence stands, see [RQ9] [RQ18]
                seq_q <= `TSH_IDX_CTL;
                phase_q <= PH_IDLE;
                cnt_q <= 4'h0;
                pending_o <= 1'b0;
            end else begin
                case (phase_q)
                    PH_IDLE: begin
                        if (port_wr) begin
                            // Three bytes in order, see [RQ4]
                            port_q[seq_q] <= bus_prev_q;
                            if (seq_q == `TSH_IDX_CTL) begin
                                pending_o <= 1'b1;    // see [RQ6]
                            end
                            if (seq_q == `TSH_IDX_ADDR) begin
                                seq_q <= `TSH_IDX_CTL;
                                phase_q <= PH_EXEC;
                                cnt_q <= EXEC_CYC;
                            end else begin
                                seq_q <= seq_q + 2'h1;
                            end
                        end
                    end
                    PH_EXEC: begin
                        cnt_q <= cnt_q - 4'h1;
                        if (cnt_q == EXEC_CYC) begin
                            op_read_q <= is_read;
                            op_reg_q <= tgt_reg;
                            if (!is_read && tgt_reg) begin
                                if (port_q[`TSH_IDX_ADDR] == `TSH_ADDR_SETUP) begin
                                    setup_select_o <= port_q[`TSH_IDX_DATA];    // see [RQ12]
                                end
                                if (port_q[`TSH_IDX_ADDR] == `TSH_ADDR_FSHIFT) begin
                                    frame_shift_o <= port_q[`TSH_IDX_DATA];    // see [RQ12]
                                end
                            end
                            if (!is_read && !tgt_reg) begin
                                map_we_q <= 1'b1;
                                // Location from address byte, see [RQ13]
                                map_wa_q <= port_q[`TSH_IDX_ADDR][MAP_AW-1:0];
                                // Control low bits on top, see [RQ14]
                                map_wd_q <= {ctl_b[1:0], port_q[`TSH_IDX_DATA]};
                            end
                        end
                        if (cnt_q == 4'h1) begin
                            // Finishes within the access time, see [RQ6]
                            pending_o <= 1'b0;
                            seq_q <= `TSH_IDX_CTL;    // see [RQ18]
                            if (op_read_q) begin
                                phase_q <= PH_READY;
                                // Result replaces data, see [RQ15] [RQ17]
                                if (op_reg_q) begin
                                    port_q[`TSH_IDX_DATA] <= reg_rd;
                                    port_q[`TSH_IDX_CTL][1:0] <= 2'h3;
                                end else begin
                                    port_q[`TSH_IDX_DATA] <= map_host_data[7:0];
                                    port_q[`TSH_IDX_CTL][1:0] <= map_host_data[9:8];
                                end
                            end else begin
                                phase_q <= PH_IDLE;
                            end
                        end
                    end
                    PH_READY, PH_RBK: begin
                        if (port_rd) begin
                            phase_q <= PH_RBK;
                            if (seq_q == `TSH_IDX_CTL) begin
                                pending_o <= 1'b1;    // see [RQ16]
                            end
                            if (seq_q == `TSH_IDX_ADDR) begin
                                seq_q <= `TSH_IDX_CTL;
                                phase_q <= PH_DONE;
                                cnt_q <= BUSY_CYC;
                            end else begin
                                seq_q <= seq_q + 2'h1;
                            end
                        end
                    end
                    PH_DONE: begin
                        cnt_q <= cnt_q - 4'h1;
                        if (cnt_q == 4'h1) begin
                            // Mechanism reset after readback, see [RQ16] [RQ18]
                            pending_o <= 1'b0;
                            phase_q <= PH_IDLE;
                        end
                    end
                    default: begin
                        phase_q <= PH_IDLE;
                        seq_q <= `TSH_IDX_CTL;
                        pending_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Direct registers and bus drive
    // ----------------------------------------
    wire [7:0] flags;
    assign flags = {pending_o, mem_reset_busy_i, data_loss_i, 5'h00};

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            operating_control_o <= `TSH_OC_RST;
            host_bus_o <= 8'h00;
            host_bus_oe_o <= 1'b0;
        end else begin
            // Served in any phase of the indirect sequence, see [RQ8]
            if (oc_wr) begin
                operating_control_o <= bus_prev_q;    // see [RQ2]
            end
            if (rd_start) begin
                host_bus_oe_o <= 1'b1;
                // Control register never read back, see [RQ2] [RQ3]
                host_bus_o <= (sel_s == `TSH_SEL_PORT) ? port_view : flags;
            end else if (rd_b_s || cs_b_s) begin
                host_bus_oe_o <= 1'b0;
            end
        end
    end

endmodule

// ==== verification/tsh_host_port_chk.sv ====
// Pin and register checks for the time switch host port.
// Assumes a bind to tsh_host_port and host strobes of several clocks.
module tsh_host_port_chk (
    input logic clk_sys_i, // System clock
    input logic rst_b_i, // Async reset, active low
    input logic register_select_line_i, // Port select
    input logic cs_b_i, // Chip select, active low
    input logic wr_b_i, // Write strobe, active low
    input logic rd_b_i, // Read strobe, active low
    input logic host_bus_oe_o, // Bus drive enable
    input logic [7:0] operating_control_o, // Control register
    input logic [7:0] setup_select_o, // Setup register
    input logic [7:0] frame_shift_o, // Frame shift register
    input logic pending_o // Indirect busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] idle_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // Busy time with the host idle; any strobe restarts it
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            idle_q <= 4'h0;
        end else if (!pending_o || !wr_b_i || !rd_b_i) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hf) begin
            idle_q <= idle_q + 4'h1;
        end
    end

    AST_NO_DRIVE_UNSELECTED: assert property (cs_b_i [*5] |-> !host_bus_oe_o)
        else $error("bus driven while unselected");
    AST_NO_DRIVE_UNREAD: assert property (rd_b_i [*5] |-> !host_bus_oe_o)
        else $error("bus driven without read");
    AST_OE_CAUSE: assert property ($rose(host_bus_oe_o) |->
        !rd_b_i && !cs_b_i && !$past(rd_b_i, 2))
        else $error("bus drive without read strobe");
    AST_CTRL_CAUSE: assert property ($changed(operating_control_o) |->
        !register_select_line_i
        && (!$past(wr_b_i, 3) || !$past(wr_b_i, 4) || !$past(wr_b_i, 5)))
        else $error("control changed without direct write");
    AST_ABORT: assert property ($rose(operating_control_o[6]) |-> ##[0:2] !pending_o)
        else $error("abort left access pending");
    AST_PEND_CAUSE: assert property ($rose(pending_o) |-> register_select_line_i)
        else $error("pending set outside port access");
    AST_IND_REG_WRITE: assert property (!$stable({setup_select_o, frame_shift_o})
        |-> pending_o)
        else $error("indirect register changed outside access");
    // Nine idle clocks is the access time once the host has let go
    AST_PEND_BOUND: assert property (idle_q <= 4'h9)
        else $error("pending held too long");

    cover property ($rose(pending_o));
    cover property ($fell(pending_o) && operating_control_o[6]);
    cover property ($rose(host_bus_oe_o) && register_select_line_i);
endmodule

// ==== verification/tsh_host_bfm.sv ====
// Host processor model driving the port pins, one access per call.
// Assumes the bench resolves the bus level and feeds it to bus_i.
module tsh_host_bfm (
    input wire logic clk_sys_i, // System clock
    input wire logic [7:0] bus_i, // Resolved bus level
    output logic [7:0] bus_o, // Host drive value
    output logic sel_o, // Register select line
    output logic cs_b_o, // Chip select, active low
    output logic wr_b_o, // Write strobe, active low
    output logic rd_b_o // Read strobe, active low
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        bus_o = 8'h00;
        sel_o = 1'b0;
        cs_b_o = 1'b1;
        wr_b_o = 1'b1;
        rd_b_o = 1'b1;
    end

    // Strobes last five clocks; a released bus shows the inverse value
    task automatic acc(input logic rd, input logic sel, input logic cs_b,
                       input logic [7:0] wd, output logic [7:0] rdat);
        @(posedge clk_sys_i);
        #1;
        sel_o = sel;
        cs_b_o = cs_b;
        bus_o = wd;
        @(posedge clk_sys_i);
        #1;
        wr_b_o = rd;
        rd_b_o = !rd;
        repeat (5) @(posedge clk_sys_i);
        rdat = bus_i;
        #1;
        wr_b_o = 1'b1;
        rd_b_o = 1'b1;
        cs_b_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        bus_o = ~wd;
        repeat (4) @(posedge clk_sys_i);
        // Return off the edge so callers see settled outputs
        #1;
    endtask
endmodule

// ==== verification/tsh_host_port_tb.sv ====
// Self-checking bench for the time switch host port.
// Assumes the host model drives every pin; bus level is resolved here.
`include "tsh_defs.vh"
module tsh_host_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic mem_reset_busy_i = 1'b0;
    logic data_loss_i = 1'b0;
    logic [7:0] map_scan_addr_i = 8'h00;
    logic [7:0] host_bus_o, operating_control_o, setup_select_o, frame_shift_o, host_drv;
    logic host_bus_oe_o, pending_o, sel, cs_b, wr_b, rd_b;
    logic [9:0] map_scan_data_o;
    wire [7:0] host_bus_i = host_bus_oe_o ? host_bus_o : host_drv;
    int err_total = 0;
    int checks_done = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    tsh_host_port i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .host_bus_i(host_bus_i),
        .host_bus_o(host_bus_o), .host_bus_oe_o(host_bus_oe_o), .register_select_line_i(sel),
        .cs_b_i(cs_b), .wr_b_i(wr_b), .rd_b_i(rd_b), .mem_reset_busy_i(mem_reset_busy_i),
        .data_loss_i(data_loss_i), .map_scan_addr_i(map_scan_addr_i),
        .map_scan_data_o(map_scan_data_o), .operating_control_o(operating_control_o),
        .setup_select_o(setup_select_o), .frame_shift_o(frame_shift_o), .pending_o(pending_o));
    tsh_host_bfm i_host (.clk_sys_i(clk_sys_i), .bus_i(host_bus_i), .bus_o(host_drv),
        .sel_o(sel), .cs_b_o(cs_b), .wr_b_o(wr_b), .rd_b_o(rd_b));

    task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic s, input logic [7:0] d);
        logic [7:0] x;
        i_host.acc(1'b0, s, 1'b0, d, x);
    endtask

    task automatic rd(input logic s, output logic [7:0] d);
        i_host.acc(1'b1, s, 1'b0, 8'h00, d);
    endtask

    // Bounded wait; a stuck flag counts once and ends the run
    task automatic wait_idle();
        int n;
        n = 0;
        while (pending_o !== 1'b0 && n < 8) begin
            @(posedge clk_sys_i);
            n++;
        end
        #1;
        cmp("pending_o", 10'h0, {9'h0, pending_o});
        if (pending_o !== 1'b0) begin
            summarize();
        end
    endtask

    task automatic ind(input logic [7:0] c, input logic [7:0] d, input logic [7:0] a);
        logic [7:0] f;
        rd(1'b0, f);
        cmp("flags busy", 10'h0, {8'h0, f[7:6]});
        wr(1'b1, c);
        wr(1'b1, d);
        wr(1'b1, a);
        wait_idle();
    endtask

    task automatic rb(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
        logic [7:0] b;
        rd(1'b1, b);
        cmp("pending_o", 10'h1, {9'h0, pending_o});
        cmp("rb ctl", {2'h0, e0}, {2'h0, b});
        rd(1'b1, b);
        cmp("rb data", {2'h0, e1}, {2'h0, b});
        rd(1'b1, b);
        cmp("rb addr", {2'h0, e2}, {2'h0, b});
        wait_idle();
    endtask

    task automatic chk_map(input logic [7:0] a, input logic [9:0] e);
        @(posedge clk_sys_i);
        #1;
        map_scan_addr_i = a;
        repeat (2) @(posedge clk_sys_i);
        #1;
        cmp("map word", e, map_scan_data_o);
    endtask

    task automatic t_reset();
        logic [7:0] f;
        cmp("control", 10'h0, {2'h0, operating_control_o});
        cmp("setup", {2'h0, `TSH_SETUP_RST}, {2'h0, setup_select_o});
        cmp("fshift", 10'h0, {2'h0, frame_shift_o});
        mem_reset_busy_i = 1'b1;
        data_loss_i = 1'b1;
        rd(1'b0, f);
        cmp("flags", 10'h60, {2'h0, f});
        #1;
        mem_reset_busy_i = 1'b0;
        data_loss_i = 1'b0;
        $display("t_reset done");
    endtask

    task automatic t_cs();
        logic [7:0] x;
        i_host.acc(1'b0, 1'b0, 1'b1, 8'h25, x);
        cmp("control", 10'h0, {2'h0, operating_control_o});
        // Host level ff must survive; a wrong drive would show flags 00
        i_host.acc(1'b1, 1'b0, 1'b1, 8'hff, x);
        cmp("bus cs", 10'hff, {2'h0, x});
        cmp("bus oe", 10'h0, {9'h0, host_bus_oe_o});
        wr(1'b0, 8'h25);
        cmp("control", 10'h25, {2'h0, operating_control_o});
        rd(1'b0, x);
        cmp("flags", 10'h0, {2'h0, x});
        wr(1'b0, 8'h00);
        $display("t_cs done");
    endtask

    task automatic t_reg();
        logic [7:0] f;
        wr(1'b1, 8'h30);
        cmp("pending_o", 10'h1, {9'h0, pending_o});
        rd(1'b0, f);
        cmp("flags pend", 10'h1, {9'h0, f[7]});
        wr(1'b1, 8'h55);
        wr(1'b1, `TSH_ADDR_FSHIFT);
        wait_idle();
        cmp("fshift", 10'h55, {2'h0, frame_shift_o});
        ind(8'h30, 8'ha5, `TSH_ADDR_SETUP);
        cmp("setup", 10'ha5, {2'h0, setup_select_o});
        ind(8'h30, 8'h11, 8'h80);
        cmp("setup", 10'ha5, {2'h0, setup_select_o});
        ind(8'h32, 8'h0f, `TSH_ADDR_FSHIFT);
        cmp("fshift", 10'h0f, {2'h0, frame_shift_o});
        ind(8'h31, 8'h00, `TSH_ADDR_SETUP);
        rb(8'hff, 8'ha5, `TSH_ADDR_SETUP);
        $display("t_reg done");
    endtask

    task automatic t_map();
        ind(8'h12, 8'h00, 8'haa);
        ind(8'h11, 8'h3c, 8'h05);
        ind(8'h21, 8'hc3, 8'h06);
        chk_map(8'haa, 10'h200);
        chk_map(8'h05, 10'h13c);
        chk_map(8'h06, 10'h1c3);
        ind(8'h00, 8'hff, 8'haa);
        rb(8'hce, 8'h00, 8'haa);
        chk_map(8'haa, 10'h200);
        $display("t_map done");
    endtask

    task automatic t_abort();
        wr(1'b1, 8'h30);
        cmp("pending_o", 10'h1, {9'h0, pending_o});
        wr(1'b0, 8'h40);
        cmp("pending_o", 10'h0, {9'h0, pending_o});
        cmp("control", 10'h40, {2'h0, operating_control_o});
        wr(1'b0, 8'h00);
        ind(8'h30, 8'h3c, `TSH_ADDR_FSHIFT);
        cmp("fshift", 10'h3c, {2'h0, frame_shift_o});
        ind(8'h31, 8'h00, `TSH_ADDR_FSHIFT);
        rb(8'hff, 8'h3c, `TSH_ADDR_FSHIFT);
        $display("t_abort done");
    endtask

    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_b_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        t_reset();
        t_cs();
        t_reg();
        t_map();
        t_abort();
        summarize();
    end
endmodule

bind tsh_host_port tsh_host_port_chk i_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .register_select_line_i(register_select_line_i), .cs_b_i(cs_b_i), .wr_b_i(wr_b_i),
    .rd_b_i(rd_b_i), .host_bus_oe_o(host_bus_oe_o), .operating_control_o(operating_control_o),
    .setup_select_o(setup_select_o), .frame_shift_o(frame_shift_o), .pending_o(pending_o));
